// file: verilog/cict_cycle_timer.v
// instruction timing sequencer for the pipelined core
// How it works
// - count execution in plain clock cycles only
// - cycles usually equal instruction byte count
// - untaken conditional branch ends one cycle sooner
// - external move goes to three targets
// - register arithmetic: one byte, one cycle
// - direct arithmetic: two bytes, two cycles
// - indirect arithmetic: one byte, two cycles
// - immediate to accumulator: two bytes, cycles
// - logic immediate into direct: three, three
// - logic accumulator into direct: two, two
// - accumulator-only operations: one byte, cycle
// - direct to direct move: three, three
// - direct or immediate to register: two
// - indirect move to accumulator: one, two
// - standard encoding kept; only timing differs
// - taken-branch cache miss adds penalty cycles
// - spare opcode behaves exactly as no-op
`timescale 1ns/100ps
`default_nettype none
`include "cict_timing_map.vh"
module cict_cycle_timer (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire start_in,
    input wire [7:0] opcode_in,
    input wire branch_in,
    input wire [3:0] branch_cycles_in,
    input wire branch_taken_in,
    input wire cache_miss_in,
    input wire [3:0] miss_penalty_in,
    input wire [1:0] xmove_sel_in,
    output wire ready_out,
    output reg [1:0] length_out,
    output reg [3:0] cycles_out,
    output reg [1:0] xmove_target_out,
    output reg is_nop_out,
    output reg illegal_out,
    output wire done_out
);
    localparam [0:0] ST_IDLE = `CICT_ST_IDLE;
    localparam [0:0] ST_BUSY = `CICT_ST_BUSY;
    reg state_ff;
    reg [3:0] count_ff;
    reg [3:0] nxt_count;
    reg nxt_state;
    reg [3:0] total;
    wire [1:0] t_len;
    wire [3:0] t_cyc;
    wire t_xmove;
    wire t_nop;
    wire t_known;
    wire take;
    cict_opcode_table u_table (
        .opcode_in(opcode_in),
        .length_out(t_len),
        .cycles_out(t_cyc),
        .is_xmove_out(t_xmove),
        .is_nop_out(t_nop),
        .known_out(t_known)
    );
    assign ready_out = (state_ff == ST_IDLE);
    assign take = start_in && ready_out;
    // branch: listed taken count, one less untaken, plus miss penalty when taken
    always @* begin
        total = t_cyc;
        if (branch_in) begin
            if (branch_taken_in) begin
                total = branch_cycles_in;
            end else begin
                total = branch_cycles_in - `CICT_CYC_1;
            end
            if (branch_taken_in && cache_miss_in) begin
                total = total + miss_penalty_in;
            end
        end
    end
    // one count per clock, no machine-cycle grouping
    always @* begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_count = total;
                    nxt_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                nxt_count = count_ff - `CICT_CNT_ONE;
                if (count_ff == `CICT_CNT_ONE) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_count = `CICT_CNT_ZERO;
            end
        endcase
    end
    assign done_out = (state_ff == ST_BUSY) &&
        (count_ff == `CICT_CNT_ONE);
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= ST_IDLE;
            count_ff <= `CICT_CNT_ZERO;
            length_out <= `CICT_LEN_1;
            cycles_out <= `CICT_CYC_1;
            xmove_target_out <= `CICT_TGT_NONE;
            is_nop_out <= 1'b0;
            illegal_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            if (take) begin
                length_out <= branch_in ? length_out : t_len;
                cycles_out <= total;
                is_nop_out <= t_nop;
                illegal_out <= !t_known && !branch_in;
                if (t_xmove) begin
                    xmove_target_out <= xmove_sel_in;
                end else begin
                    xmove_target_out <= `CICT_TGT_NONE;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/cict_timing_map.vh
// constants for the instruction length and cycle timing decoder
`ifndef CICT_TIMING_MAP_VH
`define CICT_TIMING_MAP_VH
`define CICT_OPC_NOP 8'h00
`define CICT_OPC_SPARE 8'hA5
`define CICT_OPC_INC_DPTR 8'hA3
`define CICT_OPC_MUL 8'hA4
`define CICT_OPC_DIV 8'h84
`define CICT_OPC_DA 8'hD4
`define CICT_OPC_MOV_DIR_DIR 8'h85
`define CICT_OPC_EXTERNAL_DATA_MOVE_RD_RI0 8'hE2
`define CICT_OPC_EXTERNAL_DATA_MOVE_RD_RI1 8'hE3
`define CICT_OPC_EXTERNAL_DATA_MOVE_RD_DP 8'hE0
`define CICT_OPC_EXTERNAL_DATA_MOVE_WR_RI0 8'hF2
`define CICT_OPC_EXTERNAL_DATA_MOVE_WR_RI1 8'hF3
`define CICT_OPC_EXTERNAL_DATA_MOVE_WR_DP 8'hF0
`define CICT_OPC_CLR_A 8'hE4
`define CICT_OPC_CPL_A 8'hF4
`define CICT_OPC_RL_A 8'h23
`define CICT_OPC_RLC_A 8'h33
`define CICT_OPC_RR_A 8'h03
`define CICT_OPC_RRC_A 8'h13
`define CICT_OPC_SWAP_A 8'hC4
`define CICT_OPC_INC_A 8'h04
`define CICT_OPC_DEC_A 8'h14
`define CICT_HI_INC 4'h0
`define CICT_HI_DEC 4'h1
`define CICT_HI_ADD 4'h2
`define CICT_HI_ADD_WITH_CARRY 4'h3
`define CICT_HI_ORL 4'h4
`define CICT_HI_ANL 4'h5
`define CICT_HI_XRL 4'h6
`define CICT_HI_MOV_IMM 4'h7
`define CICT_HI_SUBTRACT_WITH_BORROW 4'h9
`define CICT_HI_MOV_DIR 4'hA
`define CICT_HI_MOV_A_SRC 4'hE
`define CICT_LO_IMM 4'h4
`define CICT_LO_DIR 4'h5
`define CICT_LO_RI0 4'h6
`define CICT_LO_RI1 4'h7
`define CICT_LO_DIR_A 4'h2
`define CICT_LO_DIR_IMM 4'h3
`define CICT_CNT_W 4
`define CICT_CNT_ZERO 4'h0
`define CICT_CNT_ONE 4'h1
`define CICT_LEN_1 2'h1
`define CICT_LEN_2 2'h2
`define CICT_LEN_3 2'h3
`define CICT_CYC_1 4'h1
`define CICT_CYC_2 4'h2
`define CICT_CYC_3 4'h3
`define CICT_CYC_4 4'h4
`define CICT_CYC_8 4'h8
`define CICT_TGT_NONE 2'h0
`define CICT_TGT_ONCHIP 2'h1
`define CICT_TGT_OFFCHIP 2'h2
`define CICT_TGT_FLASH 2'h3
`define CICT_ST_IDLE 1'b0
`define CICT_ST_BUSY 1'b1
`endif

// file: verilog/cict_opcode_table.v
// combinational opcode length, cycle and class table
`timescale 1ns/100ps
`default_nettype none
`include "cict_timing_map.vh"
module cict_opcode_table (
    input wire [7:0] opcode_in,
    output reg [1:0] length_out,
    output reg [3:0] cycles_out,
    output reg is_xmove_out,
    output reg is_nop_out,
    output reg known_out
);
    wire [3:0] hi;
    wire [3:0] lo;
    wire is_reg;
    wire is_ind;
    assign hi = opcode_in[7:4];
    assign lo = opcode_in[3:0];
    assign is_reg = opcode_in[3];
    assign is_ind = (lo == `CICT_LO_RI0) || (lo == `CICT_LO_RI1);
    always @* begin
        length_out = `CICT_LEN_1;
        cycles_out = `CICT_CYC_1;
        is_xmove_out = 1'b0;
        is_nop_out = 1'b0;
        known_out = 1'b1;
        if (opcode_in == `CICT_OPC_NOP ||
            opcode_in == `CICT_OPC_SPARE) begin
            is_nop_out = 1'b1;
        end else if (opcode_in == `CICT_OPC_MUL) begin
            cycles_out = `CICT_CYC_4;
        end else if (opcode_in == `CICT_OPC_DIV) begin
            cycles_out = `CICT_CYC_8;
        end else if (opcode_in == `CICT_OPC_MOV_DIR_DIR) begin
            length_out = `CICT_LEN_3;
            cycles_out = `CICT_CYC_3;
        end else if (opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_RD_RI0 ||
            opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_RD_RI1 ||
            opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_RD_DP ||
            opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_WR_RI0 ||
            opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_WR_RI1 ||
            opcode_in == `CICT_OPC_EXTERNAL_DATA_MOVE_WR_DP) begin
            is_xmove_out = 1'b1;
            cycles_out = `CICT_CYC_3;
        end else if (opcode_in == `CICT_OPC_INC_DPTR ||
            opcode_in == `CICT_OPC_DA ||
            opcode_in == `CICT_OPC_CLR_A ||
            opcode_in == `CICT_OPC_CPL_A ||
            opcode_in == `CICT_OPC_RL_A ||
            opcode_in == `CICT_OPC_RLC_A ||
            opcode_in == `CICT_OPC_RR_A ||
            opcode_in == `CICT_OPC_RRC_A ||
            opcode_in == `CICT_OPC_SWAP_A ||
            opcode_in == `CICT_OPC_INC_A ||
            opcode_in == `CICT_OPC_DEC_A) begin
            cycles_out = `CICT_CYC_1;
        end else if (hi == `CICT_HI_INC || hi == `CICT_HI_DEC ||
            hi == `CICT_HI_ADD || hi == `CICT_HI_ADD_WITH_CARRY ||
            hi == `CICT_HI_SUBTRACT_WITH_BORROW || hi == `CICT_HI_MOV_A_SRC ||
            ((hi == `CICT_HI_ORL || hi == `CICT_HI_ANL ||
            hi == `CICT_HI_XRL) && lo > `CICT_LO_DIR_IMM)) begin
            if (is_reg) begin
                cycles_out = `CICT_CYC_1;
            end else if (is_ind) begin
                cycles_out = `CICT_CYC_2;
            end else if (lo == `CICT_LO_DIR) begin
                length_out = `CICT_LEN_2;
                cycles_out = `CICT_CYC_2;
            end else if (lo == `CICT_LO_IMM) begin
                length_out = `CICT_LEN_2;
                cycles_out = `CICT_CYC_2;
            end else begin
                known_out = 1'b0;
            end
        end else if ((hi == `CICT_HI_ORL || hi == `CICT_HI_ANL ||
            hi == `CICT_HI_XRL) && lo == `CICT_LO_DIR_A) begin
            length_out = `CICT_LEN_2;
            cycles_out = `CICT_CYC_2;
        end else if ((hi == `CICT_HI_ORL || hi == `CICT_HI_ANL ||
            hi == `CICT_HI_XRL) && lo == `CICT_LO_DIR_IMM) begin
            length_out = `CICT_LEN_3;
            cycles_out = `CICT_CYC_3;
        end else if ((hi == `CICT_HI_MOV_IMM || hi == `CICT_HI_MOV_DIR)
            && is_reg) begin
            length_out = `CICT_LEN_2;
            cycles_out = `CICT_CYC_2;
        end else if (hi == `CICT_HI_MOV_IMM && lo == `CICT_LO_IMM) begin
            length_out = `CICT_LEN_2;
            cycles_out = `CICT_CYC_2;
        end else begin
            known_out = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/cict_timing_properties.sv
// timing assertions bound to the cycle timer
`timescale 1ns/100ps
`default_nettype none
module cict_timing_properties (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [7:0] opcode_in,
    input wire logic branch_in,
    input wire logic [3:0] branch_cycles_in,
    input wire logic branch_taken_in,
    input wire logic cache_miss_in,
    input wire logic [3:0] miss_penalty_in,
    input wire logic [1:0] xmove_sel_in,
    input wire logic ready_out,
    input wire logic [1:0] length_out,
    input wire logic [3:0] cycles_out,
    input wire logic [1:0] xmove_target_out,
    input wire logic is_nop_out,
    input wire logic done_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire tk = start_in && ready_out && !branch_in;
    wire tb = start_in && ready_out && branch_in;
    wire [5:0] lc = {length_out, cycles_out};
    logic [3:0] cnt_ff;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) cnt_ff <= 4'h0;
        else if (start_in && ready_out) cnt_ff <= 4'h1;
        else if (!ready_out) cnt_ff <= cnt_ff + 4'h1;
    end
    property p_busy; start_in && ready_out |=> !ready_out; endproperty
    a_busy: assert property (p_busy) else $error("busy");
    property p_done; done_out |-> cnt_ff == cycles_out ##1 ready_out;
    endproperty
    a_done: assert property (p_done) else $error("done");
    property p_one; tk && opcode_in inside {8'h28, 8'h39, 8'h9F, 8'hE4,
        8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hD4} |=> lc == 6'h11;
    endproperty
    a_one: assert property (p_one) else $error("one");
    property p_two; tk && opcode_in inside {8'h25, 8'h35, 8'h95, 8'h42,
        8'h24, 8'h34, 8'h94, 8'h54, 8'hAD, 8'h7A} |=> lc == 6'h22;
    endproperty
    a_two: assert property (p_two)
        else $error("two");
    property p_ind; tk && opcode_in inside {8'h26, 8'h37, 8'h97, 8'h06,
        8'h17, 8'hE6, 8'hE7} |=> lc == 6'h12; endproperty
    a_ind: assert property (p_ind) else $error("ind");
    property p_three; tk && opcode_in inside {8'h43, 8'h53, 8'h63, 8'h85}
        |=> lc == 6'h33; endproperty
    a_three: assert property (p_three) else $error("three");
    property p_untaken; tb && !branch_taken_in
        |=> cycles_out == $past(branch_cycles_in) - 4'h1; endproperty
    a_untaken: assert property (p_untaken) else $error("untaken");
    property p_miss; tb && branch_taken_in && cache_miss_in |=> cycles_out
        == $past(branch_cycles_in) + $past(miss_penalty_in); endproperty
    a_miss: assert property (p_miss) else $error("miss");
    property p_xmove; tk && opcode_in inside {8'hE0, 8'hE2, 8'hF2}
        |=> xmove_target_out == $past(xmove_sel_in); endproperty
    a_xmove: assert property (p_xmove) else $error("xmove");
    property p_spare; tk && opcode_in == 8'hA5 |=> is_nop_out && lc == 6'h11;
    endproperty
    a_spare: assert property (p_spare) else $error("spare");
endmodule
bind cict_cycle_timer cict_timing_properties u_chk (.*);
`default_nettype wire

// file: testbench/cict_prog_mem.sv
// program memory model feeding opcode bytes
`timescale 1ns/100ps
`default_nettype none
module cict_prog_mem (
    input wire logic [4:0] addr_in,
    output logic [7:0] data_out
);
    localparam logic [7:0] CODE [0:20] = '{8'h28, 8'h39, 8'h9F, 8'h25,
        8'h35, 8'h95, 8'h26, 8'h17, 8'h24, 8'h54, 8'h63, 8'h42, 8'hD4,
        8'h13, 8'h85, 8'hAD, 8'h7A, 8'hE7, 8'hA5, 8'hE2, 8'h40};
    assign data_out = CODE[addr_in];
endmodule
`default_nettype wire

// file: testbench/cict_cycle_timer_tb.sv
// self-checking bench for the cycle timer
`timescale 1ns/100ps
`default_nettype none
module cict_cycle_timer_tb;
    localparam logic [5:0] EXP [0:17] = '{6'h11, 6'h11, 6'h11, 6'h22,
        6'h22, 6'h22, 6'h12, 6'h12, 6'h22, 6'h22, 6'h33, 6'h22, 6'h11,
        6'h11, 6'h33, 6'h22, 6'h22, 6'h12};
    localparam logic [5:0] BEXP [0:2] = '{6'h13, 6'h12, 6'h15};
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, start = 1'b0, br = 1'b0;
    logic bt = 1'b0, cm = 1'b0;
    logic [4:0] addr = 5'h0;
    logic [3:0] bc = 4'h3, pen = 4'h2;
    logic [1:0] xs = 2'h0;
    wire [7:0] op;
    wire ready, nop, done, ill;
    wire [1:0] len, xt;
    wire [3:0] cyc;
    int mismatches = 0, n_tests = 0, i;
    cict_prog_mem u_mem (.addr_in(addr), .data_out(op));
    cict_cycle_timer u_dut (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .start_in(start), .opcode_in(op),
        .branch_in(br), .branch_cycles_in(bc), .branch_taken_in(bt),
        .cache_miss_in(cm), .miss_penalty_in(pen), .xmove_sel_in(xs),
        .ready_out(ready), .length_out(len), .cycles_out(cyc),
        .xmove_target_out(xt), .is_nop_out(nop), .illegal_out(ill),
        .done_out(done));
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [4:0] a, input logic [5:0] e);
        int n;
        @(posedge ref_clk_in) begin
            start <= 1'b1;
            addr <= a;
        end
        @(posedge ref_clk_in) start <= 1'b0;
        #1;
        chk({2'h0, len, cyc}, {2'h0, e});
        n = 1;
        while (done !== 1'b1 && n < 16) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        chk(8'(n), {4'h0, e[3:0]});
        @(posedge ref_clk_in);
        #1;
        chk({7'h0, ready}, 8'h01);
    endtask
    task t_table;
        for (i = 0; i < 3; i++) run(5'(i), EXP[i]);
        for (i = 3; i < 6; i++) run(5'(i), EXP[i]);
        for (i = 6; i < 8; i++) run(5'(i), EXP[i]);
        for (i = 8; i < 10; i++) run(5'(i), EXP[i]);
        run(5'd10, EXP[10]);
        run(5'd11, EXP[11]);
        for (i = 12; i < 14; i++) run(5'(i), EXP[i]);
        run(5'd14, EXP[14]);
        for (i = 15; i < 17; i++) run(5'(i), EXP[i]);
        run(5'd17, EXP[17]);
    endtask
    task t_spare;
        run(5'd0, 6'h11);
        chk({7'h0, nop}, 8'h00);
        chk({6'h0, xt}, 8'h00);
        run(5'd18, 6'h11);
        chk({7'h0, nop}, 8'h01);
    endtask
    task t_xmove;
        for (i = 1; i < 4; i++) begin
            @(posedge ref_clk_in) xs <= 2'(i);
            run(5'd19, 6'h13);
            chk({6'h0, xt}, 8'(i));
        end
    endtask
    task t_branch;
        run(5'd0, 6'h11);
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk_in) begin
                br <= 1'b1;
                bt <= i != 1;
                cm <= i == 2;
            end
            run(5'd20, BEXP[i]);
            chk({7'h0, ill}, 8'h00);
        end
        @(posedge ref_clk_in) br <= 1'b0;
    endtask
    task t_refuse;
        @(posedge ref_clk_in) begin
            start <= 1'b1;
            addr <= 5'd14;
        end
        @(posedge ref_clk_in) addr <= 5'd0;
        @(posedge ref_clk_in);
        @(posedge ref_clk_in) start <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        chk({1'b0, ready, len, cyc}, 8'h73);
    endtask
    task t_illegal;
        run(5'd20, 6'h11);
        chk({7'h0, ill}, 8'h01);
    endtask
    task t_reset;
        @(posedge ref_clk_in) begin
            start <= 1'b1;
            addr <= 5'd19;
        end
        @(posedge ref_clk_in) start <= 1'b0;
        @(posedge ref_clk_in) sys_rst_in <= 1'b1;
        @(posedge ref_clk_in) begin
            sys_rst_in <= 1'b0;
            start <= 1'b1;
            addr <= 5'd0;
        end
        #1;
        chk({1'b0, ready, len, cyc}, 8'h51);
        chk({5'h0, xt, nop}, 8'h00);
        chk({7'h0, ill}, 8'h00);
        @(posedge ref_clk_in) start <= 1'b0;
        #1;
        chk({2'h0, len, cyc}, 8'h11);
        @(posedge ref_clk_in);
        #1;
        chk({7'h0, ready}, 8'h01);
    endtask
    task print_verdict;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #5000;
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_table;
        t_spare;
        t_xmove;
        t_branch;
        t_illegal;
        t_refuse;
        t_reset;
        print_verdict;
    end
endmodule
`default_nettype wire
